// ===== cxa_core.sv
// Machine-cycle sequencer with stretchable external data move
//
// Operation
// - Every machine cycle is exactly four core clock periods, one state each.
// - States run state_one, state_two, state_three, state_four in fixed order.
// - Both clock edges are used internally; keep clock duty near 50%.
// - One opcode fetch per non-access machine cycle; cycles mostly equal instruction bytes.
// - Half of all opcodes complete in a single four-clock machine cycle.
// - Ordinary instructions last one to five machine cycles.
// - External data move lasts 2 to 9 machine cycles by stretch setting.
// - Read and write strobes lengthen with the stretched move.
// - External moves target off-chip memory and memory-mapped peripherals alike.
// - Indirect form takes low address byte from bank indirect pointer.
// - Indirect form takes high address byte from port-2 output latch.
// - Pointer form takes full 16-bit address from selected data pointer.
// - Two 16-bit data pointers; select bit is LSB of register 86h.
// - Upper seven bits of pointer select are ignored and read zero.
// - Select 0 picks primary pointer, select 1 picks alternate pointer.
// - Incrementing pointer select toggles the bit, swapping active pointer.
// - Three-bit stretch field 0..7 gives moves of 2..9 machine cycles.
// - Stretch field resets to 1, giving three-cycle moves.
// - Move fetches opcode first, then drives address and accesses next cycle.
`timescale 1ns/1ps
`default_nettype none
module cxa_core
  import cxa_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Avalon-MM slave
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Instruction side
  input wire logic i_instr_valid,
  input wire logic [2:0] i_instr_cycles,
  input wire logic i_xmove,
  input wire logic i_xmove_write,
  input wire logic i_xmove_use_ptr,
  input wire logic [7:0] i_xmove_wdata,
  input wire logic [7:0] i_bank_ptr,
  input wire logic [7:0] i_port2_latch,
  input wire logic i_psel_inc,
  output logic o_instr_taken,
  output logic o_fetch,
  output logic [3:0] o_state,
  output logic o_xmove_done,
  output logic [7:0] o_xmove_rdata,
  // External data bus
  output logic [15:0] o_ext_addr,
  output logic o_ext_rd_n,
  output logic o_ext_wr_n,
  output logic [7:0] o_ext_data_out,
  output logic o_ext_data_oe_n,
  input wire logic [7:0] i_ext_data_in
);
  cxa_cyc_if cyc ();
  assign cyc.ce = i_ce;
  cxa_cyc_seq u_seq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .cyc(cyc)
  );

  logic [CXA_MCW-1:0] mc_left_reg;
  logic xmove_reg;
  logic xwrite_reg;
  logic xuseptr_reg;
  logic access_reg;
  logic acc_first_reg;
  logic psel_reg;
  logic [CXA_STR_W-1:0] stretch_reg;
  logic [15:0] dptr0_reg;
  logic [15:0] alternate_data_pointer_reg;
  logic ack_reg;
  logic strobe_next;
  logic start_access;
  logic loading;
  logic [CXA_MCW-1:0] instr_mc;
  logic [15:0] sel_ptr;
  logic [7:0] bus_idx;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_mux;

  // Bus decode: word-aligned index, lane 0 holds byte registers
  assign bus_idx = i_avs_address[9:2];
  assign bus_req = i_avs_read | i_avs_write;
  assign bus_wr = i_avs_write & ack_reg;

  assign loading = cyc.last && (mc_left_reg == '0) && i_instr_valid;
  assign start_access = cyc.last && (mc_left_reg != '0) && xmove_reg && !access_reg;
  assign sel_ptr = psel_reg ? alternate_data_pointer_reg : dptr0_reg;

  // Length in machine cycles of the instruction being taken
  always_comb begin
    if (i_xmove) begin
      instr_mc = CXA_MCW'(CXA_XMOVE_BASE_MC) + CXA_MCW'(stretch_reg);
    end else if (i_instr_cycles == 3'h0) begin
      instr_mc = CXA_MCW'(1);
    end else if (i_instr_cycles > 3'(CXA_MAX_INSTR_MC)) begin
      instr_mc = CXA_MCW'(CXA_MAX_INSTR_MC);
    end else begin
      instr_mc = CXA_MCW'(i_instr_cycles);
    end
  end

  // Instruction sequencing across machine-cycle boundaries
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mc_left_reg <= '0;
      xmove_reg <= 1'b0;
      xwrite_reg <= 1'b0;
      xuseptr_reg <= 1'b0;
      o_instr_taken <= 1'b0;
    end else if (i_ce) begin
      o_instr_taken <= loading;
      if (loading) begin
        mc_left_reg <= instr_mc - CXA_MCW'(1);
        xmove_reg <= i_xmove;
        xwrite_reg <= i_xmove_write;
        xuseptr_reg <= i_xmove_use_ptr;
      end else if (cyc.last && (mc_left_reg != '0)) begin
        mc_left_reg <= mc_left_reg - CXA_MCW'(1);
      end else if (cyc.last) begin
        xmove_reg <= 1'b0;
      end
    end
  end

  // Opcode fetch in state_one of every non-access machine cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fetch <= 1'b0;
    end else if (i_ce) begin
      o_fetch <= cyc.last && !start_access && !(access_reg && (mc_left_reg != '0));
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_state <= CXA_S1;
    end else if (i_ce) begin
      o_state <= cyc.last ? CXA_S1 : {cyc.state[2:0], 1'b0};
    end
  end

  // Access phase: address out after the fetch cycle, held to the end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      access_reg <= 1'b0;
      acc_first_reg <= 1'b0;
      o_ext_addr <= '0;
      o_ext_data_out <= '0;
      o_ext_data_oe_n <= 1'b1;
      o_xmove_done <= 1'b0;
      o_xmove_rdata <= '0;
    end else if (i_ce) begin
      o_xmove_done <= 1'b0;
      if (start_access) begin
        access_reg <= 1'b1;
        acc_first_reg <= 1'b1;
        if (xuseptr_reg) begin
          o_ext_addr <= sel_ptr;
        end else begin
          o_ext_addr <= {i_port2_latch, i_bank_ptr};
        end
        o_ext_data_oe_n <= !xwrite_reg;
      end else if (access_reg && cyc.last) begin
        acc_first_reg <= 1'b0;
        if (mc_left_reg == '0) begin
          access_reg <= 1'b0;
          o_ext_data_oe_n <= 1'b1;
          o_xmove_done <= 1'b1;
        end
      end
      if (loading && i_xmove && i_xmove_write) begin
        o_ext_data_out <= i_xmove_wdata;
      end
      // Read data taken at end of state_three while strobe still low
      if (access_reg && !xwrite_reg && (mc_left_reg == '0) && (cyc.state == CXA_S3)) begin
        o_xmove_rdata <= i_ext_data_in;
      end
    end
  end

  // Strobe window spans all access cycles, so it grows with stretch
  assign strobe_next = access_reg && !(acc_first_reg && (cyc.state == CXA_S1)) &&
                       !((mc_left_reg == '0) && (cyc.state == CXA_S4));

  // Falling-edge strobes give a clock and a half of address setup and at least half a clock of hold
  always_ff @(negedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ext_rd_n <= 1'b1;
      o_ext_wr_n <= 1'b1;
    end else if (i_ce) begin
      o_ext_rd_n <= !(strobe_next && !xwrite_reg);
      o_ext_wr_n <= !(strobe_next && xwrite_reg);
    end
  end

  // Pointer select; a bus write in the same cycle beats an increment
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      psel_reg <= CXA_PSEL_RST;
    end else if (i_ce) begin
      if (bus_wr && (bus_idx == CXA_IDX_PSEL) && i_avs_byteenable[0]) begin
        psel_reg <= i_avs_writedata[CXA_PSEL_BIT];
      end else if (i_psel_inc) begin
        psel_reg <= !psel_reg;
      end
    end
  end

  // Software-written configuration and data pointers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stretch_reg <= CXA_STRETCH_RST;
      dptr0_reg <= CXA_PRIMARY_DATA_POINTER_RST;
      alternate_data_pointer_reg <= CXA_PRIMARY_DATA_POINTER_RST;
    end else if (i_ce && bus_wr) begin
      if ((bus_idx == CXA_IDX_CLKCTL) && i_avs_byteenable[0]) begin
        stretch_reg <= i_avs_writedata[CXA_STR_LO +: CXA_STR_W];
      end
      if (bus_idx == CXA_IDX_DPTR0) begin
        if (i_avs_byteenable[0]) dptr0_reg[7:0] <= i_avs_writedata[7:0];
        if (i_avs_byteenable[1]) dptr0_reg[15:8] <= i_avs_writedata[15:8];
      end
      if (bus_idx == CXA_IDX_ALTERNATE_DATA_POINTER) begin
        if (i_avs_byteenable[0]) alternate_data_pointer_reg[7:0] <= i_avs_writedata[7:0];
        if (i_avs_byteenable[1]) alternate_data_pointer_reg[15:8] <= i_avs_writedata[15:8];
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (bus_idx)
      CXA_IDX_DPTR0: rd_mux[15:0] = dptr0_reg;
      CXA_IDX_ALTERNATE_DATA_POINTER: rd_mux[15:0] = alternate_data_pointer_reg;
      CXA_IDX_PSEL: rd_mux[CXA_PSEL_BIT] = psel_reg;
      CXA_IDX_CLKCTL: rd_mux[CXA_STR_LO +: CXA_STR_W] = stretch_reg;
      CXA_IDX_STATUS: begin
        rd_mux[CXA_ST_BUSY] = (mc_left_reg != '0);
        rd_mux[CXA_ST_ACCESS] = access_reg;
        rd_mux[CXA_ST_STATE_LO +: CXA_STATES_PER_MC] = cyc.state;
        rd_mux[CXA_ST_LEFT_LO +: CXA_MCW] = mc_left_reg;
      end
      default: rd_mux = '0;
    endcase
  end

  // One wait cycle per access; unmapped reads return zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_reg <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= '0;
    end else if (i_ce) begin
      ack_reg <= bus_req && !ack_reg;
      o_avs_waitrequest <= !(bus_req && !ack_reg);
      if (i_avs_read && !ack_reg) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end
endmodule
`default_nettype wire

// ===== cxa_pkg.sv
// Constants, register map and state codes for the machine-cycle sequencer
package cxa_pkg;
  localparam int CXA_STATES_PER_MC = 4;
  localparam int CXA_XMOVE_BASE_MC = 2;
  localparam int CXA_MAX_INSTR_MC = 5;
  localparam int CXA_MCW = 4;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CXA_IDX_DPTR0 = 8'h82;
  localparam logic [7:0] CXA_IDX_ALTERNATE_DATA_POINTER = 8'h84;
  localparam logic [7:0] CXA_IDX_PSEL = 8'h86;
  localparam logic [7:0] CXA_IDX_CLKCTL = 8'h8e;
  localparam logic [7:0] CXA_IDX_STATUS = 8'h8f;
  // Field layout
  localparam int CXA_PSEL_BIT = 0;
  localparam int CXA_STR_LO = 0;
  localparam int CXA_STR_W = 3;
  localparam int CXA_ST_BUSY = 0;
  localparam int CXA_ST_ACCESS = 1;
  localparam int CXA_ST_STATE_LO = 4;
  localparam int CXA_ST_LEFT_LO = 8;
  // Reset values
  localparam logic [2:0] CXA_STRETCH_RST = 3'h1;
  localparam logic CXA_PSEL_RST = 1'b0;
  localparam logic [15:0] CXA_PRIMARY_DATA_POINTER_RST = 16'h0000;
  typedef enum logic [3:0] {
    CXA_S1 = 4'h1,
    CXA_S2 = 4'h2,
    CXA_S3 = 4'h4,
    CXA_S4 = 4'h8
  } cxa_state_e;
endpackage

// ===== cxa_cyc_if.sv
// Carrier between the state sequencer and the core logic
`timescale 1ns/1ps
`default_nettype none
interface cxa_cyc_if;
  import cxa_pkg::*;
  logic ce;
  cxa_state_e state;
  logic last;
  modport seq (input ce, output state, output last);
  modport core (output ce, input state, input last);
endinterface
`default_nettype wire

// ===== cxa_cyc_seq.sv
// Four-state machine-cycle ring sequencer
`timescale 1ns/1ps
`default_nettype none
module cxa_cyc_seq
  import cxa_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Cycle carrier
  cxa_cyc_if.seq cyc
);
  cxa_state_e state_reg;

  // One clock period per state, fixed order
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= CXA_S1;
    end else if (cyc.ce) begin
      unique case (state_reg)
        CXA_S1: state_reg <= CXA_S2;
        CXA_S2: state_reg <= CXA_S3;
        CXA_S3: state_reg <= CXA_S4;
        CXA_S4: state_reg <= CXA_S1;
        default: state_reg <= CXA_S1;
      endcase
    end
  end

  assign cyc.state = state_reg;
  assign cyc.last = (state_reg == CXA_S4);
endmodule
`default_nettype wire

// ===== cxa_core_props.sv
// Port-level checks of the machine-cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module cxa_core_chk (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Bus and sequencer
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_fetch,
  input wire logic o_instr_taken,
  input wire logic [3:0] o_state,
  // External bus
  input wire logic [15:0] o_ext_addr,
  input wire logic o_ext_rd_n,
  input wire logic o_ext_wr_n,
  input wire logic o_ext_data_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_ring;
    o_state == 4'h2 ##1 o_state == 4'h4 ##1 o_state == 4'h8 ##1 o_state == 4'h1;
  endsequence
  property p_ring;
    (i_ce && $rose(o_state[0])) |=> s_ring;
  endproperty
  property p_wait;
    $rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest;
  endproperty
  property p_wait_one;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  property p_fetch;
    o_fetch |-> o_state == 4'h1;
  endproperty
  property p_taken;
    o_instr_taken |-> o_fetch && o_state == 4'h1;
  endproperty
  property p_strobes;
    o_ext_rd_n || o_ext_wr_n;
  endproperty
  property p_oe;
    !o_ext_data_oe_n |-> o_ext_rd_n;
  endproperty
  property p_addr;
    (!o_ext_rd_n || !o_ext_wr_n) |-> $stable(o_ext_addr);
  endproperty
  a_ring: assert property (p_ring) else $error("state ring out of order");
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  a_wait_one: assert property (p_wait_one) else $error("answer held too long");
  a_fetch: assert property (p_fetch) else $error("fetch outside state one");
  a_taken: assert property (p_taken) else $error("take without fetch");
  a_strobes: assert property (p_strobes) else $error("both strobes low");
  a_oe: assert property (p_oe) else $error("driving during read");
  a_addr: assert property (p_addr) else $error("address moved in strobe");
endmodule
bind cxa_core cxa_core_chk i_chk (.i_clk, .i_rst, .i_ce, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .o_fetch, .o_instr_taken, .o_state, .o_ext_addr, .o_ext_rd_n,
  .o_ext_wr_n, .o_ext_data_oe_n);
`default_nettype wire

// ===== cxa_xmem.sv
// External data memory model on the strobed byte bus
`timescale 1ns/1ps
`default_nettype none
module cxa_xmem (
  // Bus from the core
  input wire logic [15:0] i_addr,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_oe_n,
  input wire logic [7:0] i_data,
  // Read data
  output logic [7:0] o_data
);
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;
  logic [7:0] idx;
  // Folded index so both address bytes matter
  assign idx = i_addr[15:8] ^ i_addr[7:0];
  always @(posedge i_wr_n) if (i_oe_n === 1'b0) mem[idx] <= i_data;
  always @(posedge i_rd_n) last <= mem[idx];
  // Released bus shows the inverse, never a stale copy
  assign o_data = i_rd_n ? ~last : mem[idx];
endmodule
`default_nettype wire

// ===== cxa_core_bench.sv
// Self-checking bench for the machine-cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module cxa_core_bench;
  import cxa_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic i_instr_valid = 1'b0, i_xmove = 1'b0, i_xmove_write = 1'b0, i_xmove_use_ptr = 1'b0;
  logic i_psel_inc = 1'b0, o_avs_waitrequest, o_instr_taken, o_fetch, o_xmove_done;
  logic o_ext_rd_n, o_ext_wr_n, o_ext_data_oe_n;
  logic [9:0] i_avs_address = '0;
  logic [31:0] i_avs_writedata = '0, o_avs_readdata, q;
  logic [3:0] i_avs_byteenable = 4'hf, o_state;
  logic [2:0] i_instr_cycles = '0;
  logic [7:0] i_xmove_wdata = '0, i_bank_ptr = '0, i_port2_latch = '0;
  logic [7:0] i_ext_data_in, o_xmove_rdata, o_ext_data_out;
  logic [15:0] o_ext_addr, ea;
  int mismatches = 0, comparisons = 0;
  cxa_core i_dut (.i_clk, .i_rst, .i_ce, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_instr_valid,
    .i_instr_cycles, .i_xmove, .i_xmove_write, .i_xmove_use_ptr, .i_xmove_wdata, .i_bank_ptr,
    .i_port2_latch, .i_psel_inc, .o_instr_taken, .o_fetch, .o_state, .o_xmove_done,
    .o_xmove_rdata, .o_ext_addr, .o_ext_rd_n, .o_ext_wr_n, .o_ext_data_out, .o_ext_data_oe_n,
    .i_ext_data_in);
  cxa_xmem i_mem (.i_addr(o_ext_addr), .i_rd_n(o_ext_rd_n), .i_wr_n(o_ext_wr_n),
    .i_oe_n(o_ext_data_oe_n), .i_data(o_ext_data_out), .o_data(i_ext_data_in));
  initial forever #5 i_clk = ~i_clk;
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    i_avs_address <= {idx, 2'b00};
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic toggle();
    i_psel_inc <= 1'b1;
    @(posedge i_clk);
    i_psel_inc <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic regs();
    bus(0, CXA_IDX_PSEL, 0);
    `CHK(q, 32'h0)
    bus(1, CXA_IDX_PSEL, 32'hff);
    bus(0, CXA_IDX_PSEL, 0);
    `CHK(q, 32'h1)
    toggle();
    bus(0, CXA_IDX_PSEL, 0);
    `CHK(q, 32'h0)
    bus(0, 8'h10, 0);
    `CHK(q, 32'h0)
    bus(1, CXA_IDX_DPTR0, 32'h1234);
    bus(1, CXA_IDX_ALTERNATE_DATA_POINTER, 32'h5678);
    bus(0, CXA_IDX_ALTERNATE_DATA_POINTER, 0);
    `CHK(q, 32'h5678)
  endtask
  task automatic plain(input logic [2:0] c, input int e);
    int n;
    n = 0;
    i_xmove <= 1'b0;
    i_instr_cycles <= c;
    i_instr_valid <= 1'b1;
    do @(posedge i_clk); while (o_instr_taken !== 1'b1);
    do begin
      @(posedge i_clk);
      n++;
    end while (o_instr_taken !== 1'b1);
    i_instr_valid <= 1'b0;
    `CHK(n, 4 * e)
    // Let an edge pass so the next offer never lands in this time step
    @(posedge i_clk);
  endtask
  // Indirect bytes given the inverse on pointer moves, so a wrong source shows
  task automatic xmove(input logic w, input logic p, input logic [7:0] d, input int s);
    int n, rd, wr;
    logic [15:0] a;
    n = 0;
    rd = 0;
    wr = 0;
    a = 'x;
    i_xmove <= 1'b1;
    i_xmove_write <= w;
    i_xmove_use_ptr <= p;
    i_xmove_wdata <= d;
    i_bank_ptr <= p ? ~ea[7:0] : ea[7:0];
    i_port2_latch <= p ? ~ea[15:8] : ea[15:8];
    i_instr_valid <= 1'b1;
    do @(posedge i_clk); while (o_instr_taken !== 1'b1);
    i_instr_valid <= 1'b0;
    do begin
      @(posedge i_clk);
      n++;
      if (o_ext_rd_n === 1'b0) rd++;
      if (o_ext_wr_n === 1'b0) wr++;
      if (o_ext_rd_n === 1'b0 || o_ext_wr_n === 1'b0) a = o_ext_addr;
    end while (o_xmove_done !== 1'b1);
    `CHK(n, 4 * (s + 2))
    `CHK(w ? wr : rd, 4 * (s + 1) - 2)
    `CHK(w ? rd : wr, 0)
    `CHK(a, ea)
    if (!w) `CHK(o_xmove_rdata, d)
  endtask
  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    regs();
    for (int c = 0; c < 8; c++) plain(c, c == 0 ? 1 : (c > 5 ? 5 : c));
    // Default stretch, primary pointer selected
    ea = 16'h1234;
    xmove(1, 1, 8'h5a, 1);
    xmove(0, 0, 8'h5a, 1);
    for (int s = 0; s < 8; s++) begin
      bus(1, CXA_IDX_CLKCTL, 32'(s));
      bus(1, CXA_IDX_PSEL, 32'(s % 2));
      ea = (s % 2) ? 16'h5678 : 16'h1234;
      xmove(1, 1, 8'(s) ^ 8'ha5, s);
      toggle();
      xmove(0, 0, 8'(s) ^ 8'ha5, s);
    end
    end_sim();
  end
  // Whole run needs about 800 cycles
  initial begin
    #50000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
